// ---- verilog/hpmb_pkg.sv ----
// shared constants for the buffer and its controller
package hpmb_pkg;
    // controller registers, byte offsets on the apb bus
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] BURST_OFS = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;
    // ctrl fields, all active high in the register
    localparam int HOST_ADDR_SEL_BIT = 0;
    localparam int HOST_DATA_SEL_BIT = 1;
    localparam int MEM_DATA_SEL_BIT = 2;
    localparam int PCI_SEL_BIT = 3;
    localparam int FLAG_BIT = 4;
    localparam int READ_HOLD_BIT = 5;
    localparam int LE_BIT = 6;
    localparam int BYPASS_BIT = 7;
    localparam int SNOOP_OE_BIT = 8;
    localparam int SIZE_LSB = 9;
    localparam int CTRL_W = 11;
    localparam logic [10:0] CTRL_RST = 11'h000;
    // status fields
    localparam int ST_PAR_OK_BIT = 0;
    localparam int ST_AD_PAR_BIT = 1;
    localparam int ST_MSB_BIT = 2;
    localparam int ST_FLAG_PEND_BIT = 3;
    localparam int ST_BURST_BUSY_BIT = 4;
    // transfer size codes and low address masks for little endian
    localparam logic [1:0] SIZE_1B = 2'h0;
    localparam logic [1:0] SIZE_2B = 2'h1;
    localparam logic [1:0] SIZE_4B = 2'h2;
    localparam logic [2:0] XOR_1B = 3'h7;
    localparam logic [2:0] XOR_2B = 3'h6;
    localparam logic [2:0] XOR_4B = 3'h4;
    localparam logic [2:0] XOR_8B = 3'h0;
    // memory parity sense: 0 even, 1 odd
    localparam logic PAR_ODD = 1'b0;
    // timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int BURST_LOW_NS = 100;
    localparam int BURST_LOW_CYC = (BURST_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : hpmb_pkg

// ---- verilog/hpmb_link_if.sv ----
// link between the datapath buffer and its bridge controller
`timescale 1ns/1ps
`default_nettype none
interface hpmb_link_if (
    input wire logic pci_clk
);
    logic host_addr_sel_n;
    logic host_data_sel_n;
    logic mem_data_sel_n;
    logic pci_sel_n;
    logic address_phase_flag;
    logic burst_strobe_n;
    logic pci_read_hold_n;
    logic little_endian_select_n;
    logic translation_bypass;
    logic host_addr_oe_n;
    logic [1:0] xfer_size;
    logic memory_parity_ok;
    logic ad_parity;
    logic pci_addr_msb;

    modport device (
        input pci_clk, host_addr_sel_n, host_data_sel_n, mem_data_sel_n, pci_sel_n,
        input address_phase_flag, burst_strobe_n, pci_read_hold_n,
        input little_endian_select_n, translation_bypass, host_addr_oe_n, xfer_size,
        output memory_parity_ok, ad_parity, pci_addr_msb
    );
    modport ctrl (
        input pci_clk, memory_parity_ok, ad_parity, pci_addr_msb,
        output host_addr_sel_n, host_data_sel_n, mem_data_sel_n, pci_sel_n,
        output address_phase_flag, burst_strobe_n, pci_read_hold_n,
        output little_endian_select_n, translation_bypass, host_addr_oe_n, xfer_size
    );
endinterface : hpmb_link_if
`default_nettype wire

// ---- verilog/hpmb_controller.sv ----
// bridge controller end: apb registers steering the buffer strobes
`timescale 1ns/1ps
`default_nettype none
module hpmb_controller (
    // clock and reset
    input wire logic REF_CLK_IN,
    input wire logic RST_B_IN,
    // apb slave
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [7:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    // link to the buffer
    hpmb_link_if.ctrl LINK
);
    logic [10:0] ctrl_q, ctrl_d;
    logic [1:0] pclk_s;
    logic pclk_d_q;
    logic flag_pend_q, flag_pend_d;
    logic [7:0] burst_cnt_q, burst_cnt_d;

    wire setup = PSEL_IN & ~PENABLE_IN;
    wire access = PSEL_IN & PENABLE_IN & PREADY_OUT;
    wire hit_ctrl = PADDR_IN == hpmb_pkg::CTRL_OFS;
    wire hit_burst = PADDR_IN == hpmb_pkg::BURST_OFS;
    wire hit_stat = PADDR_IN == hpmb_pkg::STATUS_OFS;
    wire hit = hit_ctrl | hit_burst | hit_stat;
    wire wr = access & PWRITE_IN;
    wire pclk_rise = pclk_s[1] & ~pclk_d_q;
    wire [10:0] wval = PWDATA_IN[10:0];
    // host-to-pci cycle: flag up with the pci side not selected
    wire host_pci = ctrl_q[hpmb_pkg::FLAG_BIT] & ~ctrl_q[hpmb_pkg::PCI_SEL_BIT];
    // memory start for a foreign master needs pci address msb set unless translation bypass is on
    wire mem_refuse = wval[hpmb_pkg::PCI_SEL_BIT] & ~wval[hpmb_pkg::BYPASS_BIT]
        & ~LINK.pci_addr_msb;
    wire burst_go = wr & hit_burst & ~host_pci & (burst_cnt_q == 8'h00);
    wire [31:0] status = {27'h0, (burst_cnt_q != 8'h00), flag_pend_q, LINK.pci_addr_msb,
        LINK.ad_parity, LINK.memory_parity_ok};
    wire [31:0] rdata = hit_ctrl ? {21'h0, ctrl_q} : hit_stat ? status : 32'h0;

    always_comb begin
        ctrl_d = ctrl_q;
        flag_pend_d = flag_pend_q;
        burst_cnt_d = burst_cnt_q;
        if (burst_go) begin
            burst_cnt_d = 8'(hpmb_pkg::BURST_LOW_CYC);
        end else if (burst_cnt_q != 8'h00) begin
            burst_cnt_d = burst_cnt_q - 8'h01;
        end
        // a lowered flag waits for a pci rising edge, then drops as soon as that edge is seen
        if (flag_pend_q && pclk_rise) begin
            ctrl_d[hpmb_pkg::FLAG_BIT] = 1'b0;
            flag_pend_d = 1'b0;
        end
        if (wr && hit_ctrl) begin
            ctrl_d = wval;
            if (mem_refuse) begin
                ctrl_d[hpmb_pkg::MEM_DATA_SEL_BIT] = 1'b0;
            end
            if (!wval[hpmb_pkg::FLAG_BIT] && ctrl_q[hpmb_pkg::FLAG_BIT]) begin
                ctrl_d[hpmb_pkg::FLAG_BIT] = 1'b1;
                flag_pend_d = 1'b1;
            end else begin
                flag_pend_d = 1'b0;
            end
        end
    end

    always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            ctrl_q <= hpmb_pkg::CTRL_RST;
            flag_pend_q <= 1'b0;
            burst_cnt_q <= 8'h00;
            pclk_s <= 2'h0;
            pclk_d_q <= 1'b0;
            PRDATA_OUT <= 32'h0;
            PREADY_OUT <= 1'b0;
            PSLVERR_OUT <= 1'b0;
            LINK.host_addr_sel_n <= 1'b1;
            LINK.host_data_sel_n <= 1'b1;
            LINK.mem_data_sel_n <= 1'b1;
            LINK.pci_sel_n <= 1'b1;
            LINK.address_phase_flag <= 1'b0;
            LINK.burst_strobe_n <= 1'b1;
            LINK.pci_read_hold_n <= 1'b1;
            LINK.little_endian_select_n <= 1'b1;
            LINK.translation_bypass <= 1'b0;
            LINK.host_addr_oe_n <= 1'b1;
            LINK.xfer_size <= 2'h0;
        end else begin
            ctrl_q <= ctrl_d;
            flag_pend_q <= flag_pend_d;
            burst_cnt_q <= burst_cnt_d;
            pclk_s <= {pclk_s[0], LINK.pci_clk};
            pclk_d_q <= pclk_s[1];
            PREADY_OUT <= setup;
            PRDATA_OUT <= (setup && !PWRITE_IN) ? rdata : 32'h0;
            PSLVERR_OUT <= setup & ~hit;
            LINK.host_addr_sel_n <= ~ctrl_d[hpmb_pkg::HOST_ADDR_SEL_BIT];
            LINK.host_data_sel_n <= ~ctrl_d[hpmb_pkg::HOST_DATA_SEL_BIT];
            LINK.mem_data_sel_n <= ~ctrl_d[hpmb_pkg::MEM_DATA_SEL_BIT];
            LINK.pci_sel_n <= ~ctrl_d[hpmb_pkg::PCI_SEL_BIT];
            LINK.address_phase_flag <= ctrl_d[hpmb_pkg::FLAG_BIT];
            LINK.burst_strobe_n <= burst_cnt_d == 8'h00;
            LINK.pci_read_hold_n <= ~ctrl_d[hpmb_pkg::READ_HOLD_BIT];
            LINK.little_endian_select_n <= ~ctrl_d[hpmb_pkg::LE_BIT];
            LINK.translation_bypass <= ctrl_d[hpmb_pkg::BYPASS_BIT];
            LINK.host_addr_oe_n <= ~ctrl_d[hpmb_pkg::SNOOP_OE_BIT];
            LINK.xfer_size <= ctrl_d[hpmb_pkg::SIZE_LSB +: 2];
        end
    end
endmodule : hpmb_controller
`default_nettype wire

// ---- verilog/hpmb_buffer.sv ----
// address and data path buffer between host, memory and pci buses
`timescale 1ns/1ps
`default_nettype none
module hpmb_buffer (
    // clock and reset
    input wire logic REF_CLK_IN,
    input wire logic RST_B_IN,
    // link from the controller
    hpmb_link_if.device LINK,
    // host address bus
    input wire logic [31:0] HOST_ADDR_IN,
    output logic [31:0] HOST_ADDR_OUT,
    output logic HOST_ADDR_OE_OUT,
    // host data bus
    input wire logic [63:0] HOST_DATA_IN,
    output logic [63:0] HOST_DATA_OUT,
    output logic HOST_DATA_OE_OUT,
    // memory bus
    input wire logic [63:0] MEM_DATA_IN,
    input wire logic [7:0] MEM_PAR_IN,
    output logic [63:0] MEM_DATA_OUT,
    output logic [7:0] MEM_PAR_OUT,
    output logic MEM_DATA_OE_OUT,
    output logic [31:0] MEM_ADDR_OUT,
    // pci address/data pins
    input wire logic [31:0] PCI_AD_IN,
    output logic [31:0] PCI_AD_OUT,
    output logic PCI_AD_OE_OUT
);
    logic [1:0] pclk_s;
    logic [31:0] ad_s1, ad_s2;
    logic pclk_d_q;
    logic burst_d_q;
    logic psel_d_q;
    logic [31:0] host_a_q;
    logic [31:0] pci_lat_q;
    logic [31:0] cnt_q;
    logic open_q;
    logic [31:0] pci_dat_q;
    logic phase_q;

    function automatic logic [63:0] lane_swap(input logic [63:0] d, input logic le);
        logic [63:0] r;
        r = d;
        if (le) begin
            for (int i = 0; i < 8; i++) begin
                r[8*i +: 8] = d[8*(7-i) +: 8];
            end
        end
        return r;
    endfunction : lane_swap

    function automatic logic [7:0] byte_par(input logic [63:0] d);
        logic [7:0] p;
        p = 8'h00;
        for (int i = 0; i < 8; i++) begin
            p[i] = (^d[8*i +: 8]) ^ hpmb_pkg::PAR_ODD;
        end
        return p;
    endfunction : byte_par

    // edges, all seen on the reference clock
    wire pclk_rise = pclk_s[1] & ~pclk_d_q;
    wire burst_fall = burst_d_q & ~LINK.burst_strobe_n;
    wire psel_fall = psel_d_q & ~LINK.pci_sel_n;
    wire le = ~LINK.little_endian_select_n;
    wire flag = LINK.address_phase_flag;

    // host address transform
    wire [1:0] size = LINK.xfer_size;
    wire [2:0] xor_m = (size == hpmb_pkg::SIZE_1B) ? hpmb_pkg::XOR_1B :
        (size == hpmb_pkg::SIZE_2B) ? hpmb_pkg::XOR_2B :
        (size == hpmb_pkg::SIZE_4B) ? hpmb_pkg::XOR_4B : hpmb_pkg::XOR_8B;
    wire [2:0] low_t = HOST_ADDR_IN[2:0] ^ (le ? xor_m : 3'h0);
    wire [31:0] host_a_t = {HOST_ADDR_IN[31:3], low_t};

    // pci address latch and translation
    wire lat_open = ~LINK.pci_sel_n & flag & ~pclk_s[1];
    wire [31:0] lat_v = lat_open ? ad_s2 : pci_lat_q;
    wire [1:0] top_in = lat_v[31:30];
    wire [1:0] top_map = top_in[1] ? {1'b0, top_in[0]} : 2'h3;
    wire [1:0] top_x = LINK.translation_bypass ? top_in : top_map;
    wire [31:0] pci_x = {top_x, lat_v[29:0]};

    // pci burst counter, transparent until the first counting strobe
    wire cnt_en = ~LINK.pci_sel_n | ~flag;
    wire [31:0] cnt_v = open_q ? pci_x : cnt_q;
    wire [29:0] cnt_inc = cnt_v[31:2] + 30'h1;

    // internal address bus
    wire [31:0] int_addr = LINK.pci_sel_n ? host_a_q : cnt_v;

    // internal data bus
    wire [63:0] host_w = lane_swap(HOST_DATA_IN, le);
    wire [63:0] pci_rep = {pci_dat_q, pci_dat_q};
    wire [63:0] int_data = !LINK.host_data_sel_n ? host_w :
        !LINK.mem_data_sel_n ? MEM_DATA_IN :
        !LINK.pci_sel_n ? pci_rep : 64'h0;
    wire [63:0] host_r = lane_swap(int_data, le);

    // pci output mux
    wire [31:0] pci_half = int_addr[2] ? int_data[63:32] : int_data[31:0];
    wire [31:0] pci_out = phase_q ? int_addr : pci_half;
    wire pci_oe = LINK.pci_sel_n & (flag | phase_q | ~LINK.host_data_sel_n);
    wire par_ok = byte_par(MEM_DATA_IN) == MEM_PAR_IN;

    // synchronisers and edge history
    always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            pclk_s <= 2'h0;
            ad_s1 <= 32'h0;
            ad_s2 <= 32'h0;
            pclk_d_q <= 1'b0;
            burst_d_q <= 1'b1;
            psel_d_q <= 1'b1;
        end else begin
            pclk_s <= {pclk_s[0], LINK.pci_clk};
            ad_s1 <= PCI_AD_IN;
            ad_s2 <= ad_s1;
            pclk_d_q <= pclk_s[1];
            burst_d_q <= LINK.burst_strobe_n;
            psel_d_q <= LINK.pci_sel_n;
        end
    end

    // host address hold latch and burst field
    always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            host_a_q <= 32'h0;
        end else if (LINK.host_addr_sel_n) begin
            host_a_q <= host_a_t;
        end else if (burst_fall && LINK.pci_sel_n) begin
            host_a_q[4:3] <= host_a_q[4:3] + 2'h1;
        end
    end

    // pci address latch
    always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            pci_lat_q <= 32'h0;
        end else if (lat_open) begin
            pci_lat_q <= ad_s2;
        end
    end

    // pci burst counter
    always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            cnt_q <= 32'h0;
            open_q <= 1'b0;
        end else if (burst_fall && cnt_en) begin
            cnt_q <= {cnt_inc, cnt_v[1:0]};
            open_q <= 1'b0;
        end else if (psel_fall) begin
            open_q <= 1'b1;
        end
    end

    // pci read data latch and address/data phase flip-flop
    always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            pci_dat_q <= 32'h0;
            phase_q <= 1'b0;
        end else if (pclk_rise) begin
            if (LINK.pci_read_hold_n) begin
                pci_dat_q <= ad_s2;
            end
            phase_q <= flag;
        end
    end

    // registered pin outputs
    always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            HOST_ADDR_OUT <= 32'h0;
            HOST_ADDR_OE_OUT <= 1'b0;
            HOST_DATA_OUT <= 64'h0;
            HOST_DATA_OE_OUT <= 1'b0;
            MEM_DATA_OUT <= 64'h0;
            MEM_PAR_OUT <= 8'h00;
            MEM_DATA_OE_OUT <= 1'b0;
            MEM_ADDR_OUT <= 32'h0;
            PCI_AD_OUT <= 32'h0;
            PCI_AD_OE_OUT <= 1'b0;
        end else begin
            HOST_ADDR_OUT <= cnt_v;
            HOST_ADDR_OE_OUT <= ~LINK.host_addr_oe_n;
            HOST_DATA_OUT <= host_r;
            HOST_DATA_OE_OUT <= (~LINK.mem_data_sel_n | ~LINK.pci_sel_n)
                & LINK.host_addr_oe_n & LINK.host_data_sel_n;
            MEM_DATA_OUT <= int_data;
            MEM_PAR_OUT <= byte_par(int_data);
            MEM_DATA_OE_OUT <= ~LINK.host_data_sel_n;
            MEM_ADDR_OUT <= int_addr;
            PCI_AD_OUT <= pci_out;
            PCI_AD_OE_OUT <= pci_oe;
        end
    end

    // status back to the controller
    always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            LINK.memory_parity_ok <= 1'b0;
            LINK.ad_parity <= 1'b0;
            LINK.pci_addr_msb <= 1'b0;
        end else begin
            LINK.memory_parity_ok <= par_ok;
            LINK.ad_parity <= ^pci_out;
            LINK.pci_addr_msb <= lat_v[31];
        end
    end
endmodule : hpmb_buffer
`default_nettype wire

// ---- tb/hpmb_asserts.sv ----
// concurrent checks on the link between buffer and controller
`timescale 1ns/1ps
`default_nettype none
module hpmb_asserts (
    // clock and reset
    input wire logic REF_CLK_IN,
    input wire logic RST_B_IN,
    // link signals
    input wire logic pci_clk,
    input wire logic pci_sel_n,
    input wire logic mem_data_sel_n,
    input wire logic address_phase_flag,
    input wire logic burst_strobe_n,
    input wire logic translation_bypass,
    input wire logic pci_addr_msb
);
    wire latch_open = !pci_sel_n && address_phase_flag;
    wire host_pci = address_phase_flag && pci_sel_n;

    default clocking cb @(posedge REF_CLK_IN);
    endclocking
    default disable iff (!RST_B_IN);

    chk_burst_low_width: assert property (
        $fell(burst_strobe_n) |=> !burst_strobe_n [*3] ##1 burst_strobe_n)
        else $error("burst strobe low pulse has wrong width");
    chk_burst_rise_gap: assert property (
        $rose(burst_strobe_n) |-> $past(burst_strobe_n, 5) && !$past(burst_strobe_n, 4))
        else $error("burst strobe rose after wrong low time");
    chk_no_host_burst: assert property (
        host_pci |-> !$fell(burst_strobe_n))
        else $error("burst strobe pulsed during host to pci cycle");
    chk_flag_drop_edge: assert property (
        $fell(address_phase_flag) |-> $past(pci_clk, 1) || $past(pci_clk, 2))
        else $error("address phase flag dropped away from pci clock rise");
    chk_flag_min_high: assert property (
        $rose(address_phase_flag) |=> address_phase_flag)
        else $error("address phase flag pulse too short");
    chk_msb_hold_closed: assert property (
        $changed(pci_addr_msb) |-> $past(latch_open, 1) || $past(latch_open, 2)
            || $past(latch_open, 3) || $past(latch_open, 4))
        else $error("pci address changed while latch closed");
    chk_msb_clk_low: assert property (
        $changed(pci_addr_msb) |-> !($past(pci_clk, 2) && $past(pci_clk, 3)
            && $past(pci_clk, 4) && $past(pci_clk, 5)))
        else $error("pci address changed while pci clock high");
    chk_mem_sel_refuse: assert property (
        $fell(mem_data_sel_n) && !pci_sel_n && !translation_bypass |-> $past(pci_addr_msb))
        else $error("memory cycle started for low pci address");

    cov_pci_burst: cover property ($fell(burst_strobe_n) && !pci_sel_n);
    cov_flag_drop: cover property ($fell(address_phase_flag));
    cov_pci_mem: cover property ($fell(mem_data_sel_n) && !pci_sel_n);
endmodule : hpmb_asserts
`default_nettype wire

// ---- tb/tb_top.sv ----
// self-checking bench joining the buffer and its controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int has = 1 << hpmb_pkg::HOST_ADDR_SEL_BIT, hds = 1 << hpmb_pkg::HOST_DATA_SEL_BIT;
    localparam int mds = 1 << hpmb_pkg::MEM_DATA_SEL_BIT, psl = 1 << hpmb_pkg::PCI_SEL_BIT;
    localparam int flg = 1 << hpmb_pkg::FLAG_BIT, rhd = 1 << hpmb_pkg::READ_HOLD_BIT;
    localparam int leb = 1 << hpmb_pkg::LE_BIT, byp = 1 << hpmb_pkg::BYPASS_BIT;
    localparam int sno = 1 << hpmb_pkg::SNOOP_OE_BIT;
    localparam logic [7:0] ct = hpmb_pkg::CTRL_OFS, st = hpmb_pkg::STATUS_OFS;
    logic clk = 1'b0, rst_b = 1'b0, pclk = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [7:0] paddr = 8'h00, mpi = 8'h00, mpo;
    logic [31:0] pwdata = 32'h0, hai = 32'h0, pai = 32'h0, prd, hao, mao, pao, rd;
    logic [63:0] hdi = 64'h0, mdi = 64'h0, hdo, mdo;
    logic prdy, perr, haoe, hdoe, mdoe, paoe, err;
    int n_errors = 0, checks = 0, cyc_n = 0;

    always #12.5 clk = ~clk;
    always #100 pclk = ~pclk;

    hpmb_link_if link (.pci_clk(pclk));
    hpmb_controller i_hpmb_controller (.REF_CLK_IN(clk), .RST_B_IN(rst_b), .PSEL_IN(psel),
        .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
        .PRDATA_OUT(prd), .PREADY_OUT(prdy), .PSLVERR_OUT(perr), .LINK(link.ctrl));
    hpmb_buffer i_hpmb_buffer (.REF_CLK_IN(clk), .RST_B_IN(rst_b), .LINK(link.device),
        .HOST_ADDR_IN(hai), .HOST_ADDR_OUT(hao), .HOST_ADDR_OE_OUT(haoe), .HOST_DATA_IN(hdi),
        .HOST_DATA_OUT(hdo), .HOST_DATA_OE_OUT(hdoe), .MEM_DATA_IN(mdi), .MEM_PAR_IN(mpi),
        .MEM_DATA_OUT(mdo), .MEM_PAR_OUT(mpo), .MEM_DATA_OE_OUT(mdoe), .MEM_ADDR_OUT(mao),
        .PCI_AD_IN(pai), .PCI_AD_OUT(pao), .PCI_AD_OE_OUT(paoe));
    hpmb_asserts i_hpmb_asserts (.REF_CLK_IN(clk), .RST_B_IN(rst_b), .pci_clk(link.pci_clk),
        .pci_sel_n(link.pci_sel_n), .mem_data_sel_n(link.mem_data_sel_n),
        .address_phase_flag(link.address_phase_flag), .burst_strobe_n(link.burst_strobe_n),
        .translation_bypass(link.translation_bypass), .pci_addr_msb(link.pci_addr_msb));

    function automatic logic [63:0] sw(input logic [63:0] x, input logic le);
        logic [63:0] y;
        for (int i = 0; i < 8; i++) y[8*i+:8] = x[8*(7-i)+:8];
        return le ? y : x;
    endfunction : sw

    function automatic logic [7:0] par(input logic [63:0] x);
        logic [7:0] p;
        for (int i = 0; i < 8; i++) p[i] = ^x[8*i+:8] ^ hpmb_pkg::PAR_ODD;
        return p;
    endfunction : par

    function automatic logic [2:0] msk(input logic [1:0] s);
        case (s)
            hpmb_pkg::SIZE_1B: return hpmb_pkg::XOR_1B;
            hpmb_pkg::SIZE_2B: return hpmb_pkg::XOR_2B;
            hpmb_pkg::SIZE_4B: return hpmb_pkg::XOR_4B;
            default: return hpmb_pkg::XOR_8B;
        endcase
    endfunction : msk

    task automatic chk(input logic [71:0] s, input logic [71:0] e);
        checks++;
        if (s !== e) begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    // one apb transfer, waits for pready; only the bench timeout ends a hang
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (prdy !== 1'b1);
        rd = prd;
        err = perr;
        psel <= 1'b0;
        pen <= 1'b0;
        chk(n, 1);
    endtask : apb

    task automatic wr(input logic [31:0] d);
        apb(1'b1, ct, d);
    endtask : wr

    task automatic end_of_test;
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_of_test

    always @(posedge clk) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 5000) begin
            n_errors++;
            end_of_test();
        end
    end

    initial begin
        logic [31:0] a;
        logic [1:0] t;
        int cfg;
        cyc(6);
        rst_b <= 1'b1;
        cyc(4);
        // memory write and read, both endian modes
        for (int le = 0; le < 2; le++) begin
            hdi <= 64'h0123_4567_89AB_CDEF;
            wr(hds | (le[0] ? leb : 0));
            cyc(2);
            chk(mdo, sw(hdi, le[0]));
            chk({mdoe, mpo}, {1'b1, par(sw(hdi, le[0]))});
            chk(link.host_data_sel_n, 1'b0);
            mdi <= 64'hFEDC_BA98_7654_3210;
            mpi <= par(64'hFEDC_BA98_7654_3210) ^ {7'h00, le[0]};
            wr(mds | (le[0] ? leb : 0));
            cyc(2);
            chk({hdoe, hdo}, {1'b1, sw(mdi, le[0])});
            apb(1'b0, st, 32'h0);
            chk(rd[hpmb_pkg::ST_PAR_OK_BIT], !le[0]);
        end
        // low address bits for every size and mode
        hai <= 32'h0000_0ABD;
        for (int i = 0; i < 8; i++) begin
            cfg = (i[2] ? leb : 0) | (i[1:0] << hpmb_pkg::SIZE_LSB);
            wr(cfg);
            wr(cfg | has);
            cyc(2);
            chk(mao, {hai[31:3], hai[2:0] ^ (i[2] ? msk(i[1:0]) : 3'h0)});
        end
        // host burst wraps in bits 4:3
        for (int k = 1; k < 6; k++) begin
            apb(1'b1, hpmb_pkg::BURST_OFS, 32'h0);
            cyc(6);
            chk(mao, {hai[31:5], hai[4:3] + k[1:0], hai[2:0]});
        end
        // host to pci write: address phase then data phase
        hai <= 32'h1234_5674;
        hdi <= 64'h1111_2222_AAAA_5555;
        wr(32'h0);
        wr(has | hds | flg);
        cyc(32);
        chk({paoe, pao}, {1'b1, hai});
        apb(1'b0, st, 32'h0);
        chk(rd[hpmb_pkg::ST_AD_PAR_BIT], ^hai);
        apb(1'b1, hpmb_pkg::BURST_OFS, 32'h0);
        cyc(6);
        chk(mao, hai);
        wr(has | hds);
        cyc(32);
        chk({paoe, pao}, {1'b1, hdi[63:32]});
        apb(1'b0, st, 32'h0);
        chk(rd[hpmb_pkg::ST_AD_PAR_BIT], ^hdi[63:32]);
        // host to pci read, then held
        pai <= 32'hC0DE_1234;
        wr(psl);
        cyc(32);
        chk({hdoe, hdo}, {1'b1, pai, pai});
        wr(psl | rhd);
        pai <= 32'h5A5A_0F0F;
        cyc(32);
        chk(hdo, {32'hC0DE_1234, 32'hC0DE_1234});
        // foreign master address for every top code, with and without bypass
        for (int i = 0; i < 8; i++) begin
            a = {i[1:0], 30'h0123_4566};
            cfg = sno | psl | (i[2] ? byp : 0);
            wr(32'h0);
            pai <= a;
            wr(cfg | flg);
            cyc(24);
            wr(cfg | mds);
            cyc(24);
            pai <= ~a;
            cyc(8);
            t = i[2] ? a[31:30] : (a[31] ? {1'b0, a[30]} : 2'b11);
            chk(mao[29:0], a[29:0]);
            chk({haoe, hao}, {1'b1, t, a[29:0]});
            apb(1'b0, ct, 32'h0);
            chk(rd[hpmb_pkg::MEM_DATA_SEL_BIT], a[31] | i[2]);
            apb(1'b1, hpmb_pkg::BURST_OFS, 32'h0);
            apb(1'b0, st, 32'h0);
            chk(rd[hpmb_pkg::ST_BURST_BUSY_BIT], 1'b1);
            chk(rd[hpmb_pkg::ST_MSB_BIT], a[31]);
            cyc(6);
            chk(hao, {t, a[29:2] + 28'h1, a[1:0]});
        end
        // unmapped register
        apb(1'b0, 8'h0C, 32'h0);
        chk({err, rd}, {1'b1, 32'h0});
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
